// file: pkg/ptpcc_pkg.sv
// Shared constants and types of the precision clock command block
package ptpcc_pkg;
   // Register byte offsets
   localparam int ADDR_W = 9;
   localparam logic [8:0] OFS_COMMAND = 9'h100;
   localparam logic [8:0] OFS_STATUS = 9'h108;
   localparam logic [8:0] OFS_MASK = 9'h10c;
   localparam logic [8:0] OFS_SEC = 9'h110;
   localparam logic [8:0] OFS_NS = 9'h114;
   localparam logic [8:0] OFS_SUBNS = 9'h118;
   localparam logic [8:0] OFS_TRATE = 9'h120;
   localparam logic [8:0] OFS_TDUR = 9'h124;
   localparam logic [8:0] OFS_STEP = 9'h128;
   localparam logic [8:0] OFS_TA_SEC = 9'h12c;
   localparam logic [8:0] OFS_TA_NS = 9'h130;
   localparam logic [8:0] OFS_TB_SEC = 9'h13c;
   localparam logic [8:0] OFS_TB_NS = 9'h140;

   // Command register field positions
   localparam int BIT_RESET = 0;
   localparam int BIT_DISABLE = 1;
   localparam int BIT_ENABLE = 2;
   localparam int BIT_SNAP = 3;
   localparam int BIT_LOAD = 4;
   localparam int BIT_STEP_SEC = 5;
   localparam int BIT_STEP_NS = 6;
   localparam int BIT_TRATE = 7;
   localparam int BIT_CAPTURE = 8;
   localparam int SEL_LSB = 9;
   localparam int SEL_MSB = 12;
   localparam int BIT_TGT_SNAP = 13;

   // Step register layout
   localparam int STEP_DIR_BIT = 31;
   localparam int STEP_AMT_MSB = 29;

   // Reset values and sizes
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam int NUM_SETS = 16;
   localparam logic [15:0] SET_ONE = 16'h0001;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Unit enable states
   typedef enum logic [1:0] {ST_STRAP, ST_OFF, ST_ON, ST_DRAIN} ptpcc_en_state_type;
endpackage

// file: hw/ptpcc_irq.sv
// Sticky event status bits, mask gating and interrupt level
`timescale 1ns/1ns
module ptpcc_irq
   import ptpcc_pkg::*;
#(
   parameter int N = NUM_SETS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic rst_n,
   // Events and software access
   input wire logic [N-1:0] set_vec,
   input wire logic clr,
   input wire logic [N-1:0] mask,
   // Results
   output logic [N-1:0] status,
   output logic irq
);
   logic [N-1:0] status_ff;
   logic [N-1:0] nxt_status;

   // Per bit: a new event wins over a read clear
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_comb begin
         nxt_status[i] = set_vec[i] | (status_ff[i] & ~clr);
      end
      always_ff @(posedge aclk) begin
         if (!rst_n) begin
            status_ff[i] <= 1'b0;
         end else begin
            status_ff[i] <= nxt_status[i];
         end
      end
      a_set_wins: assert property (@(posedge aclk) disable iff (!rst_n)
         set_vec[i] |=> status_ff[i]) else $error("status event lost");
   end

   // Level high while any unmasked bit stands
   assign status = status_ff;
   assign irq = |(status_ff & mask);

   a_irq_level: assert property (@(posedge aclk) disable iff (!rst_n)
      (|(set_vec & mask)) |=> irq) else $error("interrupt not raised");
endmodule

// file: hw/ptpcc_enable_ctl.sv
// Unit enable, drain-on-disable and unit reset sequencing
`timescale 1ns/1ns
module ptpcc_enable_ctl
   import ptpcc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Strap and commands
   input wire logic enable_strap,
   input wire logic cmd_enable,
   input wire logic cmd_disable,
   input wire logic cmd_reset,
   input wire logic frame_busy,
   // State
   output logic unit_enabled,
   output logic frame_start_ok,
   output logic unit_reset_strobe
);
   ptpcc_en_state_type state_ff;
   ptpcc_en_state_type nxt_state;
   logic rst_ff;
   logic nxt_rst;

   // Next state; the strap is taken in the first cycle after release
   always_comb begin
      nxt_state = state_ff;
      nxt_rst = 1'b0;
      case (state_ff)
         ST_STRAP: nxt_state = enable_strap ? ST_ON : ST_OFF;
         ST_OFF: if (cmd_enable) nxt_state = ST_ON;
         ST_ON: if (cmd_disable) nxt_state = ST_DRAIN;
         ST_DRAIN: if (!frame_busy) nxt_state = ST_OFF;
         default: nxt_state = ST_OFF;
      endcase
      if (cmd_reset) begin
         nxt_state = ST_OFF;
         nxt_rst = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_STRAP;
         rst_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rst_ff <= nxt_rst;
      end
   end

   assign unit_enabled = (state_ff == ST_ON) || (state_ff == ST_DRAIN);
   assign frame_start_ok = (state_ff == ST_ON);
   assign unit_reset_strobe = rst_ff;

   a_reset_off: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_reset |=> !unit_enabled && unit_reset_strobe) else $error("reset left unit on");
   a_drain_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_DRAIN) && frame_busy && !cmd_reset |=> unit_enabled && !frame_start_ok)
      else $error("drain ended early");
   a_enable_on: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_OFF) && cmd_enable && !cmd_reset |=> frame_start_ok)
      else $error("enable ignored");
endmodule

// file: hw/ptpcc_top.sv
// Precision clock command register bank with AXI4-Lite access
// Summary of operation
// - A target snapshot command copies both comparator targets into the target holding registers.
// - The capture select field picks edge set (top bit) and GPIO number, and resets to zero.
// - Every one of the eight GPIO numbers is a valid manual capture target.
// - A manual capture command stores the clock into the selected capture set.
// - A manual capture also sets the status bit of the selected capture set.
// - A temporary rate command starts the temporary rate for the programmed duration.
// - A nanosecond step command adds the step amount to the nanoseconds.
// - A seconds step command adds or subtracts the step amount per the direction bit.
// - A load command moves the three holding registers into the running clock.
// - A clock snapshot command copies the running clock into the holding registers.
// - Command bits are self-clearing and a written zero does nothing; all but enable are write-only and read zero.
// - Writing one to the enable bit turns the unit on and the bit reads the enabled state.
// - The disable bit stops new frames and clears enable once frames in progress finish.
// - The unit reset bit resets the unit registers and leaves the unit disabled.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module ptpcc_top
   import ptpcc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,

   // AXI4-Lite write channels
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,

   // AXI4-Lite read channels
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,

   // Present clock and comparator values
   input wire logic [31:0] time_seconds_now,
   input wire logic [31:0] time_nanosec_now,
   input wire logic [31:0] time_subnanosec_now,
   input wire logic [31:0] target_a_seconds,
   input wire logic [31:0] target_a_nanosec,
   input wire logic [31:0] target_b_seconds,
   input wire logic [31:0] target_b_nanosec,

   // Clock load and step
   output logic time_load_strobe,
   output logic [31:0] time_seconds_holding,
   output logic [31:0] time_nanosec_holding,
   output logic [31:0] time_subnanosec_holding,
   output logic nanosec_step_strobe,
   output logic seconds_step_strobe,
   output logic [STEP_AMT_MSB:0] step_amount,
   output logic step_direction,

   // Temporary rate
   output logic temp_rate_strobe,
   output logic [31:0] temporary_rate_value,
   output logic [31:0] temporary_rate_duration,

   // Manual capture
   output logic capture_strobe,
   output logic [3:0] capture_select,

   // Unit control
   input wire logic enable_strap,
   input wire logic frame_busy,
   output logic unit_enabled,
   output logic frame_start_ok,
   output logic unit_reset_strobe,

   // Interrupt
   output logic irq
);

   // Bus state
   logic bvalid_ff;
   logic nxt_bvalid;
   logic [1:0] bresp_ff;
   logic [1:0] nxt_bresp;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [1:0] rresp_ff;
   logic [1:0] nxt_rresp;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   // Software registers
   logic [3:0] sel_ff;
   logic [3:0] nxt_sel;
   logic [31:0] mask_ff;
   logic [31:0] nxt_mask;
   logic [31:0] sec_ff;
   logic [31:0] nxt_sec;
   logic [31:0] ns_ff;
   logic [31:0] nxt_ns;
   logic [31:0] subns_ff;
   logic [31:0] nxt_subns;
   logic [31:0] trate_ff;
   logic [31:0] nxt_trate;
   logic [31:0] tdur_ff;
   logic [31:0] nxt_tdur;
   logic [31:0] step_ff;
   logic [31:0] nxt_step;
   logic [31:0] ta_sec_ff;
   logic [31:0] nxt_ta_sec;
   logic [31:0] ta_ns_ff;
   logic [31:0] nxt_ta_ns;
   logic [31:0] tb_sec_ff;
   logic [31:0] nxt_tb_sec;
   logic [31:0] tb_ns_ff;
   logic [31:0] nxt_tb_ns;

   // Command strobes
   logic load_stb_ff;
   logic step_ns_stb_ff;
   logic step_sec_stb_ff;
   logic trate_stb_ff;
   logic cap_stb_ff;
   logic [3:0] cap_sel_ff;
   logic [3:0] nxt_cap_sel;

   // Decode
   logic wr_go;
   logic rd_go;
   logic [31:0] wmask;
   logic [31:0] cmd;
   logic [31:0] cmd_read;
   logic [NUM_SETS-1:0] status;
   logic [NUM_SETS-1:0] cap_event;
   logic status_clr;
   logic unit_rst_n;

   // Word address match
   function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
      return a[8:2] == o[8:2];
   endfunction

   // Any register of the map
   function automatic logic mapped(input logic [8:0] a);
      return hit(a, OFS_COMMAND) || hit(a, OFS_STATUS) || hit(a, OFS_MASK) ||
         hit(a, OFS_SEC) || hit(a, OFS_NS) || hit(a, OFS_SUBNS) ||
         hit(a, OFS_TRATE) || hit(a, OFS_TDUR) || hit(a, OFS_STEP) ||
         hit(a, OFS_TA_SEC) || hit(a, OFS_TA_NS) ||
         hit(a, OFS_TB_SEC) || hit(a, OFS_TB_NS);
   endfunction

   // Handshakes: address and data are taken together, one at a time
   assign wr_go = awvalid && wvalid && !bvalid_ff;
   assign awready = wr_go;
   assign wready = wr_go;
   assign rd_go = arvalid && !rvalid_ff;
   assign arready = !rvalid_ff;
   assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

   // Command bits act only when written as one in an enabled lane
   assign cmd = (wr_go && hit(awaddr, OFS_COMMAND)) ? (wdata & wmask) : REG_RESET;
   assign status_clr = rd_go && hit(araddr, OFS_STATUS);
   assign unit_rst_n = aresetn && !unit_reset_strobe;

   // Command register read view: select field and enable state only
   always_comb begin
      cmd_read = REG_RESET;
      cmd_read[SEL_MSB:SEL_LSB] = sel_ff;
      cmd_read[BIT_ENABLE] = unit_enabled;
   end

   // Bus response next values
   always_comb begin
      nxt_bvalid = bvalid_ff && !bready;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff && !rready;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (wr_go) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr[8:2])
            OFS_COMMAND[8:2]: nxt_rdata = cmd_read;
            OFS_STATUS[8:2]: nxt_rdata = {{(32-NUM_SETS){1'b0}}, status};
            OFS_MASK[8:2]: nxt_rdata = mask_ff;
            OFS_SEC[8:2]: nxt_rdata = sec_ff;
            OFS_NS[8:2]: nxt_rdata = ns_ff;
            OFS_SUBNS[8:2]: nxt_rdata = subns_ff;
            OFS_TRATE[8:2]: nxt_rdata = trate_ff;
            OFS_TDUR[8:2]: nxt_rdata = tdur_ff;
            OFS_STEP[8:2]: nxt_rdata = step_ff;
            OFS_TA_SEC[8:2]: nxt_rdata = ta_sec_ff;
            OFS_TA_NS[8:2]: nxt_rdata = ta_ns_ff;
            OFS_TB_SEC[8:2]: nxt_rdata = tb_sec_ff;
            OFS_TB_NS[8:2]: nxt_rdata = tb_ns_ff;
            default: nxt_rdata = REG_RESET;
         endcase
      end
   end

   // Bus response registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= REG_RESET;
      end else begin
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   // Software registers next values, snapshots override nothing else
   always_comb begin
      nxt_sel = sel_ff;
      nxt_mask = mask_ff;
      nxt_sec = sec_ff;
      nxt_ns = ns_ff;
      nxt_subns = subns_ff;
      nxt_trate = trate_ff;
      nxt_tdur = tdur_ff;
      nxt_step = step_ff;
      nxt_ta_sec = ta_sec_ff;
      nxt_ta_ns = ta_ns_ff;
      nxt_tb_sec = tb_sec_ff;
      nxt_tb_ns = tb_ns_ff;
      if (wr_go) begin
         case (awaddr[8:2])
            OFS_COMMAND[8:2]: begin
               if (wstrb[1]) nxt_sel = wdata[SEL_MSB:SEL_LSB];
            end
            OFS_MASK[8:2]: nxt_mask = (mask_ff & ~wmask) | (wdata & wmask);
            OFS_SEC[8:2]: nxt_sec = (sec_ff & ~wmask) | (wdata & wmask);
            OFS_NS[8:2]: nxt_ns = (ns_ff & ~wmask) | (wdata & wmask);
            OFS_SUBNS[8:2]: nxt_subns = (subns_ff & ~wmask) | (wdata & wmask);
            OFS_TRATE[8:2]: nxt_trate = (trate_ff & ~wmask) | (wdata & wmask);
            OFS_TDUR[8:2]: nxt_tdur = (tdur_ff & ~wmask) | (wdata & wmask);
            OFS_STEP[8:2]: nxt_step = (step_ff & ~wmask) | (wdata & wmask);
            default: nxt_sel = sel_ff;
         endcase
      end
      // Whole time value in one cycle
      if (cmd[BIT_SNAP]) begin
         nxt_sec = time_seconds_now;
         nxt_ns = time_nanosec_now;
         nxt_subns = time_subnanosec_now;
      end
      // Both comparators in one cycle
      if (cmd[BIT_TGT_SNAP]) begin
         nxt_ta_sec = target_a_seconds;
         nxt_ta_ns = target_a_nanosec;
         nxt_tb_sec = target_b_seconds;
         nxt_tb_ns = target_b_nanosec;
      end
   end

   // Software registers, cleared also by the unit reset
   always_ff @(posedge aclk) begin
      if (!unit_rst_n) begin
         sel_ff <= SEL_RESET;
         mask_ff <= REG_RESET;
         sec_ff <= REG_RESET;
         ns_ff <= REG_RESET;
         subns_ff <= REG_RESET;
         trate_ff <= REG_RESET;
         tdur_ff <= REG_RESET;
         step_ff <= REG_RESET;
         ta_sec_ff <= REG_RESET;
         ta_ns_ff <= REG_RESET;
         tb_sec_ff <= REG_RESET;
         tb_ns_ff <= REG_RESET;
      end else begin
         sel_ff <= nxt_sel;
         mask_ff <= nxt_mask;
         sec_ff <= nxt_sec;
         ns_ff <= nxt_ns;
         subns_ff <= nxt_subns;
         trate_ff <= nxt_trate;
         tdur_ff <= nxt_tdur;
         step_ff <= nxt_step;
         ta_sec_ff <= nxt_ta_sec;
         ta_ns_ff <= nxt_ta_ns;
         tb_sec_ff <= nxt_tb_sec;
         tb_ns_ff <= nxt_tb_ns;
      end
   end

   // Capture set follows the select value written with the command
   assign nxt_cap_sel = nxt_sel;

   // One-cycle command strobes
   always_ff @(posedge aclk) begin
      if (!unit_rst_n) begin
         load_stb_ff <= 1'b0;
         step_ns_stb_ff <= 1'b0;
         step_sec_stb_ff <= 1'b0;
         trate_stb_ff <= 1'b0;
         cap_stb_ff <= 1'b0;
         cap_sel_ff <= SEL_RESET;
      end else begin
         load_stb_ff <= cmd[BIT_LOAD];
         step_ns_stb_ff <= cmd[BIT_STEP_NS];
         step_sec_stb_ff <= cmd[BIT_STEP_SEC];
         trate_stb_ff <= cmd[BIT_TRATE];
         cap_stb_ff <= cmd[BIT_CAPTURE];
         cap_sel_ff <= cmd[BIT_CAPTURE] ? nxt_cap_sel : cap_sel_ff;
      end
   end

   // Outputs toward the clock core
   assign time_load_strobe = load_stb_ff;
   assign time_seconds_holding = sec_ff;
   assign time_nanosec_holding = ns_ff;
   assign time_subnanosec_holding = subns_ff;
   assign nanosec_step_strobe = step_ns_stb_ff;
   assign seconds_step_strobe = step_sec_stb_ff;
   assign step_amount = step_ff[STEP_AMT_MSB:0];
   assign step_direction = step_ff[STEP_DIR_BIT];
   assign temp_rate_strobe = trate_stb_ff;
   assign temporary_rate_value = trate_ff;
   assign temporary_rate_duration = tdur_ff;
   assign capture_strobe = cap_stb_ff;
   assign capture_select = cap_sel_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rresp = rresp_ff;
   assign rdata = rdata_ff;

   // Manual capture raises the status bit of its set
   assign cap_event = cap_stb_ff ? (SET_ONE << cap_sel_ff) : '0;

   // Sticky status, mask and interrupt line
   ptpcc_irq #(
      .N(NUM_SETS)
   ) u_irq (
      .aclk(aclk),
      .rst_n(unit_rst_n),
      .set_vec(cap_event),
      .clr(status_clr),
      .mask(mask_ff[NUM_SETS-1:0]),
      .status(status),
      .irq(irq)
   );

   // Enable, disable and unit reset
   ptpcc_enable_ctl u_enable (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable_strap(enable_strap),
      .cmd_enable(cmd[BIT_ENABLE]),
      .cmd_disable(cmd[BIT_DISABLE]),
      .cmd_reset(cmd[BIT_RESET]),
      .frame_busy(frame_busy),
      .unit_enabled(unit_enabled),
      .frame_start_ok(frame_start_ok),
      .unit_reset_strobe(unit_reset_strobe)
   );

   a_target_snap: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      cmd[BIT_TGT_SNAP] |=> ta_sec_ff == $past(target_a_seconds) &&
      tb_ns_ff == $past(target_b_nanosec)) else $error("target snapshot missed");
   a_clock_snap: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      cmd[BIT_SNAP] |=> sec_ff == $past(time_seconds_now) && ns_ff == $past(time_nanosec_now)
      && subns_ff == $past(time_subnanosec_now)) else $error("clock snapshot torn");
   a_strobe_once: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      time_load_strobe |=> !time_load_strobe && !capture_strobe) else $error("strobe held");
   a_zero_quiet: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      !cmd[BIT_STEP_NS] |=> !nanosec_step_strobe) else $error("step without command");
   a_capture_set: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      cmd[BIT_CAPTURE] |=> capture_strobe && capture_select == $past(nxt_sel))
      else $error("capture set wrong");
   a_capture_irq: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      capture_strobe |=> status[capture_select]) else $error("capture status not set");
   a_sec_step: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      cmd[BIT_STEP_SEC] |=> seconds_step_strobe && step_direction == $past(step_ff[STEP_DIR_BIT]))
      else $error("seconds step missed");
   a_temp_rate: assert property (@(posedge aclk) disable iff (!unit_rst_n)
      cmd[BIT_TRATE] |=> temp_rate_strobe ##1 !temp_rate_strobe) else $error("rate start bad");
endmodule

// file: tb/testbench.sv
// Self-checking bench for the precision clock command register bank
`timescale 1ns/1ns
module testbench
   import ptpcc_pkg::*;
();
   // Bus, clock values and unit control
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [ADDR_W-1:0] awaddr = 9'h0, araddr = 9'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] time_seconds_now = 32'h0, time_nanosec_now = 32'h0, time_subnanosec_now = 32'h0;
   logic [31:0] target_a_seconds = 32'h0, target_a_nanosec = 32'h0;
   logic [31:0] target_b_seconds = 32'h0, target_b_nanosec = 32'h0;
   logic time_load_strobe, nanosec_step_strobe, seconds_step_strobe, step_direction;
   logic temp_rate_strobe, capture_strobe, unit_enabled, frame_start_ok, unit_reset_strobe, irq;
   logic [31:0] time_seconds_holding, time_nanosec_holding, time_subnanosec_holding;
   logic [31:0] temporary_rate_value, temporary_rate_duration;
   logic [STEP_AMT_MSB:0] step_amount;
   logic [3:0] capture_select;
   logic enable_strap = 1'h0, frame_busy = 1'h0;
   logic [5:0] strb;
   logic [31:0] rd_val;
   logic [1:0] rsp;
   int n_fail = 0, num_checks = 0;
   int cnt [6];
   int refc [6];

   ptpcc_top dut (.*);

   // Clock
   always #50 aclk = ~aclk;

   // Count every strobe cycle seen at the clock edge
   assign strb = {capture_strobe, temp_rate_strobe, seconds_step_strobe, nanosec_step_strobe,
                  time_load_strobe, unit_reset_strobe};
   always @(posedge aclk) begin
      for (int k = 0; k < 6; k++) if (strb[k] === 1'h1) cnt[k] <= cnt[k] + 1;
   end

   // Verdict and end of run
   task automatic close_out();
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bounded wait on a handshake flag: 0 awready, 1 bvalid, 2 arready, 3 rvalid
   task automatic wait_hi(input int w);
      int i;
      logic f;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         f = (w == 0) ? awready : (w == 1) ? bvalid : (w == 2) ? arready : rvalid;
         if (f === 1'h1) break;
      end
      if (i == 50) begin
         n_fail++;
         close_out();
      end
   endtask

   // AXI4-Lite write, address and data offered together
   task automatic axi_wr(input logic [8:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      wait_hi(0);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      wait_hi(1);
      rsp = bresp;
   endtask

   // AXI4-Lite read
   task automatic axi_rd(input logic [8:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      wait_hi(2);
      arvalid <= 1'h0;
      wait_hi(3);
      rd_val = rdata;
      rsp = rresp;
   endtask

   // Read a register and compare
   task automatic rd_chk(input string nm, input logic [8:0] a, input logic [31:0] exp);
      axi_rd(a);
      chk(nm, rd_val, exp);
   endtask

   // Command write, then compare strobe pulse counts
   task automatic cmd(input logic [31:0] d, input logic [5:0] exp);
      axi_wr(OFS_COMMAND, d);
      @(posedge aclk);
      @(posedge aclk);
      for (int k = 0; k < 6; k++) begin
         refc[k] += exp[k];
         chk("strobe count", cnt[k], refc[k]);
      end
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      close_out();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd_chk("command reset", OFS_COMMAND, REG_RESET);
      cmd(32'h0, 6'h00);
      rd_chk("zero write", OFS_COMMAND, REG_RESET);
      // Clock snapshot
      time_seconds_now <= 32'h1234_5678;
      time_nanosec_now <= 32'h0abc_def0;
      time_subnanosec_now <= 32'h0000_00a5;
      cmd(32'h0000_0008, 6'h00);
      time_seconds_now <= 32'h0;
      rd_chk("snap sec", OFS_SEC, 32'h1234_5678);
      rd_chk("snap ns", OFS_NS, 32'h0abc_def0);
      rd_chk("snap subns", OFS_SUBNS, 32'h0000_00a5);
      // Clock load
      axi_wr(OFS_SEC, 32'h0000_0777);
      axi_wr(OFS_NS, 32'h3b9a_c9ff);
      axi_wr(OFS_SUBNS, 32'h0000_0011);
      cmd(32'h0000_0010, 6'h02);
      chk("load sec", time_seconds_holding, 32'h0000_0777);
      chk("load ns", time_nanosec_holding, 32'h3b9a_c9ff);
      chk("load subns", time_subnanosec_holding, 32'h0000_0011);
      // Steps in both directions
      axi_wr(OFS_STEP, 32'h8000_0123);
      cmd(32'h0000_0020, 6'h08);
      chk("step dir", {31'h0, step_direction}, 32'h1);
      chk("step amount", {2'h0, step_amount}, 32'h0000_0123);
      axi_wr(OFS_STEP, 32'h3fff_ffff);
      cmd(32'h0000_0040, 6'h04);
      chk("step dir add", {31'h0, step_direction}, 32'h0);
      // Temporary rate
      axi_wr(OFS_TRATE, 32'h8000_1000);
      axi_wr(OFS_TDUR, 32'h0000_0400);
      cmd(32'h0000_0080, 6'h10);
      chk("rate value", temporary_rate_value, 32'h8000_1000);
      chk("rate duration", temporary_rate_duration, 32'h0000_0400);
      // Manual capture into every set, interrupt raised and cleared
      axi_wr(OFS_MASK, 32'h0000_ffff);
      for (int s = 0; s < 16; s++) begin
         cmd(32'h0000_0100 | (s << SEL_LSB), 6'h20);
         chk("capture select", {28'h0, capture_select}, s);
         chk("irq set", {31'h0, irq}, 32'h1);
         rd_chk("select read", OFS_COMMAND, s << SEL_LSB);
         rd_chk("status", OFS_STATUS, 32'h1 << s);
         chk("irq clear", {31'h0, irq}, 32'h0);
      end
      axi_wr(OFS_MASK, 32'h0);
      cmd(32'h0000_0700, 6'h20);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd_chk("masked status", OFS_STATUS, 32'h0000_0008);
      // Target snapshot
      target_a_seconds <= 32'h0000_a001;
      target_a_nanosec <= 32'h0000_a002;
      target_b_seconds <= 32'h0000_b001;
      target_b_nanosec <= 32'h0000_b002;
      cmd(32'h0000_2000, 6'h00);
      rd_chk("target a sec", OFS_TA_SEC, 32'h0000_a001);
      rd_chk("target a ns", OFS_TA_NS, 32'h0000_a002);
      rd_chk("target b sec", OFS_TB_SEC, 32'h0000_b001);
      rd_chk("target b ns", OFS_TB_NS, 32'h0000_b002);
      // Unmapped place
      rd_chk("unmapped data", 9'h1fc, 32'h0);
      chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      axi_wr(9'h1fc, 32'hffff_ffff);
      chk("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      // Enable, then disable with a frame in progress
      cmd(32'h0000_0004, 6'h00);
      rd_chk("enabled read", OFS_COMMAND, 32'h0000_0004);
      chk("start ok", {31'h0, frame_start_ok}, 32'h1);
      frame_busy <= 1'h1;
      cmd(32'h0000_0002, 6'h00);
      chk("no new frames", {31'h0, frame_start_ok}, 32'h0);
      chk("still enabled", {31'h0, unit_enabled}, 32'h1);
      frame_busy <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("drained off", {31'h0, unit_enabled}, 32'h0);
      // Unit reset clears registers and leaves the unit off
      cmd(32'h0000_0a04, 6'h00);
      axi_wr(OFS_MASK, 32'h0000_00ff);
      cmd(32'h0000_0a01, 6'h01);
      rd_chk("reset command", OFS_COMMAND, REG_RESET);
      rd_chk("reset mask", OFS_MASK, REG_RESET);
      chk("reset off", {31'h0, unit_enabled}, 32'h0);
      // Second reset with the strap set starts the unit enabled
      enable_strap <= 1'h1;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      chk("strap on", {31'h0, unit_enabled}, 32'h1);
      rd_chk("strap read", OFS_COMMAND, 32'h0000_0004);
      close_out();
   end
endmodule
